/* logic/rxerr_judge.sv */
// Purpose: Classifies one finished frame into the four error events
// Assumes: Inputs valid on the frame_end cycle
// Notes:   Pure combinational; the top registers the result
`timescale 1ns/1ps
`default_nettype none
module rxerr_judge
  import rxerr_pkg::*;
(
  // Frame summary
  input  wire rxerr_frame_t frame,
  input  wire logic         short_accept,
  input  wire logic         loopback,
  // Classified events
  output logic              discard,
  output rxerr_flags_t      events
);

  logic [LEN_W-1:0] short_limit;

  always_comb begin
    short_limit = short_accept ? SHORT_ACCEPT_LEN : MIN_FRAME_LEN;
    discard     = {5'h00, frame.byte_count} > frame.free_space;
    events.short_frame_flag = (frame.byte_count <= short_limit) && !frame.own_transmit_frame;
    events.alignment_error_flag = frame.fcs_bad && ((frame.extra_bits & BYTE_BITS_MASK) != 3'h0);
    events.crc_error_flag = frame.fcs_bad && !frame.own_transmit_frame;
    events.buffer_overflow_flag = discard && !loopback;
  end

endmodule // rxerr_judge
`default_nettype wire

/* logic/rxerr_pkg.sv */
// Purpose: Shared constants and types for the receive error status flags
// Assumes: Avalon-MM register access, 32-bit data, byte addresses
// Notes:   Flags occupy bits 3..0 of the receive status word
package rxerr_pkg;

  localparam int unsigned ADDR_W        = 4;
  localparam int unsigned LEN_W         = 11;
  localparam int unsigned FREE_W        = 16;

  localparam logic [ADDR_W-1:0] OFF_STATUS  = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'h4;

  localparam int unsigned BIT_OVERFLOW  = 0;
  localparam int unsigned BIT_CRC       = 1;
  localparam int unsigned BIT_ALIGN     = 2;
  localparam int unsigned BIT_SHORT     = 3;

  localparam int unsigned CTL_SHORT_ACCEPT = 0;
  localparam int unsigned CTL_LOOPBACK     = 1;

  localparam logic [3:0]       FLAGS_RESET   = 4'h0;
  localparam logic [1:0]       CONTROL_RESET = 2'h0;
  localparam logic [LEN_W-1:0] MIN_FRAME_LEN = 11'h03C;
  localparam logic [LEN_W-1:0] SHORT_ACCEPT_LEN = 11'h006;
  localparam logic [2:0]       BYTE_BITS_MASK = 3'h7;

  typedef struct packed {
    logic             frame_start;
    logic             frame_end;
    logic [LEN_W-1:0] byte_count;
    logic [2:0]       extra_bits;
    logic             fcs_bad;
    logic             own_transmit_frame;
    logic [FREE_W-1:0] free_space;
  } rxerr_frame_t;

  typedef struct packed {
    logic short_frame_flag;
    logic alignment_error_flag;
    logic crc_error_flag;
    logic buffer_overflow_flag;
  } rxerr_flags_t;

endpackage

/* logic/rxerr_status.sv */
// Purpose: Receive error status flags with Avalon-MM register access
// Assumes: Frame summary from the receive engine, synchronous to clock
// Notes:   One-wait-state slave; waitrequest low one cycle after request
//
// Operation
// - Short flag for frames up to 60 bytes
// - Short accept mode limits flag to 6 bytes
// - No short flag on own-transmit collision
// - Alignment flag: bad FCS, non-octet bit count
// - CRC flag on bad FCS, not own collision
// - Too large frame discarded, overflow flagged
// - Later fitting frame still stored normally
// - No overflow flag in loopback
// - Write one clears flag, zero keeps
// - New frame clears all four flags
`timescale 1ns/1ps
`default_nettype none
module rxerr_status
  import rxerr_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rstn,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  output logic [1:0]             avs_response,
  // Receive engine
  input  wire rxerr_frame_t      frame,
  output logic                   frame_discard,
  // Flag view
  output rxerr_flags_t           flags
);

  logic         rst_meta_q;
  logic         rst_sync_q;
  logic         srst_n;
  rxerr_flags_t flags_q;
  rxerr_flags_t flags_d;
  rxerr_flags_t events;
  logic [1:0]   control_q;
  logic         discard;
  logic         wait_q;
  logic [31:0]  rdata_q;
  logic [1:0]   resp_q;
  logic         discard_q;
  logic         req;
  logic [3:0]   clear_mask;

  // Reset release through two flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign srst_n = rst_sync_q;

  rxerr_judge u_judge (
    .frame        (frame),
    .short_accept (control_q[CTL_SHORT_ACCEPT]),
    .loopback     (control_q[CTL_LOOPBACK]),
    .discard      (discard),
    .events       (events)
  );

  assign req = (avs_read || avs_write) && wait_q;
  assign clear_mask = (req && avs_write && avs_address == OFF_STATUS && avs_byteenable[0])
                      ? avs_writedata[3:0] : 4'h0;

  // Priority: frame start clears, then host clears, then end-of-frame events set
  always_comb begin
    flags_d = flags_q;
    if (frame.frame_start) begin
      flags_d = FLAGS_RESET;
    end
    flags_d = rxerr_flags_t'(flags_d & ~clear_mask);
    if (frame.frame_end) begin
      flags_d = rxerr_flags_t'(flags_d | events);
    end
  end

  always_ff @(posedge clock or negedge srst_n) begin
    if (!srst_n) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Control register: short accept and loopback
  always_ff @(posedge clock or negedge srst_n) begin
    if (!srst_n) begin
      control_q <= CONTROL_RESET;
    end else if (req && avs_write && avs_address == OFF_CONTROL && avs_byteenable[0]) begin
      control_q <= avs_writedata[1:0];
    end
  end

  // Discard decision registered for the buffer manager; fitting frames pass
  always_ff @(posedge clock or negedge srst_n) begin
    if (!srst_n) begin
      discard_q <= 1'b0;
    end else begin
      discard_q <= frame.frame_end && discard;
    end
  end

  // One-wait bus answer keeps every output registered, waitrequest included
  always_ff @(posedge clock or negedge srst_n) begin
    if (!srst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
      resp_q  <= 2'h0;
    end else begin
      wait_q <= !req;
      resp_q <= 2'h0;
      if (req) begin
        unique case (avs_address)
          OFF_STATUS:  rdata_q <= {28'h000_0000, flags_q};
          OFF_CONTROL: rdata_q <= {30'h0000_0000, control_q};
          default: begin
            rdata_q <= 32'h0000_0000;
            resp_q  <= 2'h2;
          end
        endcase
      end
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;
  assign avs_response    = resp_q;
  assign frame_discard   = discard_q;
  assign flags           = flags_q;

endmodule // rxerr_status
`default_nettype wire

/* test/rxerr_host.sv */
// Purpose: Host model, Avalon-MM master
// Assumes: One request at a time
// Notes: Waits on waitrequest, no fixed latency
`timescale 1ns/1ps
`default_nettype none
module rxerr_host
  import rxerr_pkg::*;
(
  // Bus
  input  wire logic              clock,
  input  wire logic [31:0]       rdat,
  input  wire logic              wreq,
  input  wire logic [1:0]        rsp,
  output var logic [ADDR_W-1:0] adr,
  output var logic              rd_en,
  output var logic              wr_en,
  output var logic [31:0]       wdat
);
  logic [1:0] last_rsp = 2'h0;
  initial begin
    adr = '0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wdat = '0;
  end
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] q);
    adr <= a;
    wdat <= d;
    wr_en <= w;
    rd_en <= !w;
    do @(posedge clock); while (wreq !== 1'b0);
    q = rdat;
    last_rsp = rsp;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clock);
  endtask
endmodule // rxerr_host
`default_nettype wire

/* test/rxerr_status_properties.sv */
// Purpose: Flag timing checks
// Assumes: Flags follow frame_end by one edge
// Notes: Bound to the top
`timescale 1ns/1ps
`default_nettype none
module rxerr_status_properties
  import rxerr_pkg::*;
(
  // Ports watched
  input wire logic              clock,
  input wire logic              rstn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic              avs_waitrequest,
  input wire rxerr_frame_t      frame,
  input wire logic              frame_discard,
  input wire rxerr_flags_t      flags
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic [3:0] f;
  assign f = flags;
  chk_w1c_clear: assert property (
    avs_write && avs_waitrequest && avs_address == OFF_STATUS && avs_byteenable[0] && !frame.frame_start
    && !frame.frame_end |=> f == ($past(f) & ~$past(avs_writedata[3:0]))) else $error("clear wrong");
  chk_start_clear: assert property (frame.frame_start && !frame.frame_end |=> f == 4'h0)
    else $error("start clear wrong");
  chk_short_set: assert property (
    frame.frame_end && !frame.own_transmit_frame && frame.byte_count <= SHORT_ACCEPT_LEN
    |=> flags.short_frame_flag) else $error("short missing");
  chk_own_coll: assert property (frame.frame_start ##1 frame.frame_end && frame.own_transmit_frame
    |=> !flags.short_frame_flag && !flags.crc_error_flag) else $error("own frame flagged");
  chk_align_set: assert property (frame.frame_end && frame.fcs_bad && frame.extra_bits != 3'h0
    |=> flags.alignment_error_flag) else $error("align missing");
  chk_crc_set: assert property (frame.frame_end && frame.fcs_bad && !frame.own_transmit_frame
    |=> flags.crc_error_flag) else $error("crc missing");
  chk_discard_big: assert property (frame.frame_end && frame.byte_count > frame.free_space
    |=> frame_discard) else $error("no discard");
  chk_ovf_cause: assert property ($rose(flags.buffer_overflow_flag)
    |-> $past(frame.frame_end && frame.byte_count > frame.free_space)) else $error("stray overflow");
  cover property (f == 4'hE);
  cover property (frame_discard);
  cover property (avs_write && !avs_waitrequest);
endmodule // rxerr_status_properties
bind rxerr_status rxerr_status_properties chk (.*);
`default_nettype wire

/* test/test_rxerr_status.sv */
// Purpose: Bench for receive error flags
// Assumes: 10 MHz clock
// Notes: The whole 32-bit status word is judged, upper bits expected zero
`timescale 1ns/1ps
`default_nettype none
module test_rxerr_status
  import rxerr_pkg::*;
;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] adr;
  logic rd_en, wr_en, wreq, disc;
  logic [31:0] wdat, rdat, q;
  logic [1:0] resp;
  rxerr_frame_t fr = '0;
  rxerr_flags_t fl;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  always #50 clock = ~clock;
  rxerr_host host (.clock(clock), .rdat(rdat), .wreq(wreq), .rsp(resp), .adr(adr), .rd_en(rd_en), .wr_en(wr_en),
    .wdat(wdat));
  rxerr_status uut (.clock(clock), .rstn(rstn), .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
    .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .avs_response(resp), .frame(fr), .frame_discard(disc), .flags(fl));
  task automatic wrap_up;
    $display("compares=%0d miscompares=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Start pulse, then end pulse with the frame summary
  task automatic frm(input logic [10:0] n, input logic [2:0] x, input logic bad, own, input logic [15:0] fs);
    fr.frame_start <= 1'b1;
    @(posedge clock);
    fr <= '{1'b0, 1'b1, n, x, bad, own, fs};
    @(posedge clock);
    fr <= '0;
    @(negedge clock);
    cmp({31'h0, disc}, {31'h0, n > fs});
    @(posedge clock);
  endtask
  task automatic st(input logic [3:0] e);
    host.acc(1'b0, OFF_STATUS, 32'h0, q);
    cmp(q, {28'h0, e});
    cmp({28'h0, fl}, {28'h0, e});
  endtask
  task automatic sc_flags;
    st(4'h0);
    frm(11'h03C, 3'h3, 1'b1, 1'b0, 16'h0100);
    st(4'hE);
    host.acc(1'b1, OFF_STATUS, 32'h6, q);
    st(4'h8);
    frm(11'h03D, 3'h0, 1'b0, 1'b0, 16'h0010);
    st(4'h1);
    frm(11'h03D, 3'h0, 1'b0, 1'b0, 16'h0100);
    st(4'h0);
  endtask
  task automatic sc_modes;
    frm(11'h03C, 3'h0, 1'b1, 1'b1, 16'h0100);
    st(4'h0);
    host.acc(1'b1, OFF_CONTROL, 32'h1, q);
    frm(11'h007, 3'h0, 1'b0, 1'b0, 16'h0100);
    st(4'h0);
    frm(11'h006, 3'h0, 1'b0, 1'b0, 16'h0100);
    st(4'h8);
    host.acc(1'b1, OFF_CONTROL, 32'h3, q);
    frm(11'h040, 3'h0, 1'b0, 1'b0, 16'h0008);
    st(4'h0);
    host.acc(1'b0, 4'h8, 32'h0, q);
    cmp(q, 32'h0);
    cmp({30'h0, host.last_rsp}, 32'h2);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    sc_flags;
    sc_modes;
    wrap_up;
  end
  // Hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      wrap_up;
    end
  end
endmodule // test_rxerr_status
`default_nettype wire
